/* src/sarcc_params.svh */
// Purpose: Named constants for the conversion sequencer.
// Assumes: System clock of 250 MHz.
// Notes:   Times are kept in their own unit; cycle counts derive from them.
`ifndef SARCC_PARAMS_SVH
`define SARCC_PARAMS_SVH

`define SARCC_CLK_PERIOD_PS   4000
`define SARCC_NBITS           12
`define SARCC_GATED_CYCLES    13
`define SARCC_DONE_DELAY_NS   40
`define SARCC_DONE_DELAY_CYC  ((`SARCC_DONE_DELAY_NS * 1000) / `SARCC_CLK_PERIOD_PS)
`define SARCC_CONV_PW_NS      100
`define SARCC_DIV_HALF        8'h04
`define SARCC_STEP_W          4
`define SARCC_DLY_W           4
`define SARCC_ALL_ONES        12'hfff
`define SARCC_MSB_TRIAL       12'h7ff

`endif

/* src/sarcc_pkg.sv */
// Purpose: Shared types of the conversion sequencer.
// Assumes: Included parameters header supplies the word width; the state type is a fixed 2 bits.
// Notes:   Output word travels as one packed struct.
`include "sarcc_params.svh"

package sarcc_pkg;

    typedef logic [`SARCC_NBITS-1:0] sarcc_word_t;

    typedef enum logic [1:0]
    {
        SARCC_IDLE,
        SARCC_ARMED,
        SARCC_STEP,
        SARCC_HOLD
    } sarcc_state_t;

    typedef struct packed
    {
        sarcc_word_t data_n;
        logic        msb_inv;
        logic        status;
        logic        clk_out;
    } sarcc_out_t;

endpackage

/* src/sarcc_sync.sv */
// Purpose: Two-stage synchroniser for pin inputs.
// Assumes: Input is asynchronous to clock.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps

module sarcc_sync
(
    input  wire logic clock,
    input  wire logic srst,
    input  wire logic async_in,
    output logic      sync_out
);
    import sarcc_pkg::*;

    typedef struct packed
    {
        logic meta;
        logic stable;
    } sarcc_sync_st_t;

    sarcc_sync_st_t s_q;
    sarcc_sync_st_t s_d;

    always_comb
    begin
        s_d        = s_q;
        s_d.meta   = async_in;
        s_d.stable = s_q.meta;
        if (srst)
        begin
            s_d = '0;
        end
    end

    always_ff @(posedge clock)
    begin
        s_q <= s_d;
    end

    assign sync_out = s_q.stable;
endmodule

/* src/sarcc_clkgen.sv */
// Purpose: Produces the gated conversion clock as a divided strobe.
// Assumes: Runs only while enabled; held low while inhibited.
// Notes:   Emits one-cycle pulses on its rising and falling edges.
`timescale 1ns/1ps
`include "sarcc_params.svh"

module sarcc_clkgen
(
    input  wire logic clock,
    input  wire logic srst,
    input  wire logic run,
    output logic      gclk,
    output logic      rise,
    output logic      fall
);
    import sarcc_pkg::*;

    typedef struct packed
    {
        logic [7:0] cnt;
        logic       lvl;
    } sarcc_cg_t;

    sarcc_cg_t c_q;
    sarcc_cg_t c_d;
    logic      wrap;

    always_comb
    begin
        c_d  = c_q;
        wrap = (c_q.cnt == `SARCC_DIV_HALF - 8'h01);
        if (!run)
        begin
            c_d = '0;
        end
        else if (wrap)
        begin
            c_d.cnt = 8'h00;
            c_d.lvl = ~c_q.lvl;
        end
        else
        begin
            c_d.cnt = c_q.cnt + 8'h01;
        end
        if (srst)
        begin
            c_d = '0;
        end
    end

    always_ff @(posedge clock)
    begin
        c_q <= c_d;
    end

    // Clock is low while inhibited, so the first edge out is a rising one.
    assign gclk = c_q.lvl;
    assign rise = run && wrap && !c_q.lvl;
    assign fall = run && wrap && c_q.lvl;
endmodule

/* src/sarcc_top.sv */
// Purpose: Sequencing logic of a 12-bit successive-approximation converter.
// Assumes: Comparator and request are pins, synchronised here; single clock.
// Notes:   The gated clock is a divided strobe of the system clock.
`timescale 1ns/1ps
`include "sarcc_params.svh"

// Notes on behaviour
// - Status high from request arrival until conversion ends.
// - Request arrival sets status flag.
// - Status high lets gated clock run 13 cycles.
// - Request falling edge initialises register, step count, inhibit.
// - First step: MSB trial low, others high.
// - Step n keeps bit n, trials bit n+1.
// - Stepping ends with LSB decision, twelfth step.
// - Decide from comparator, MSB to LSB.
// - Trial register drives outputs and feedback converter.
// - Status clears 40 ns after final decision.
// - Clearing status reinhibits clock, held low.
// - Data outputs change only on gated clock rising edges and request falling edge.
// - Thirteen falling edges; first loads invalid bit.
// - Output bits are complement of binary result.
// - MSB or inverted MSB selects coding.
module sarcc_top
(
    input  wire logic                  clock,
    input  wire logic                  srst,
    input  wire logic                  convert_req,
    input  wire logic                  comp_keep,
    output sarcc_pkg::sarcc_word_t     data_n,
    output logic                       msb_inv,
    output logic                       status,
    output logic                       gated_clk,
    output sarcc_pkg::sarcc_word_t     dac_code,
    output sarcc_pkg::sarcc_out_t      out_bundle
);
    import sarcc_pkg::*;

    typedef struct packed
    {
        sarcc_state_t             state;
        logic                     req_prev;
        logic                     status;
        logic                     inhibit;
        sarcc_word_t              trial;
        logic [`SARCC_STEP_W-1:0] step;
        logic [`SARCC_STEP_W-1:0] falls;
        logic [`SARCC_DLY_W-1:0]  dly;
    } sarcc_st_t;

    sarcc_st_t r_q;
    sarcc_st_t r_d;
    logic      req_s;
    logic      comp_s;
    logic      g_rise;
    logic      g_fall;
    logic      g_lvl;

    // Position of the bit being decided at step n (1-based, MSB = step 1).
    function automatic sarcc_word_t bit_mask(input logic [`SARCC_STEP_W-1:0] n);
        sarcc_word_t m;
        m = '0;
        if ((n != '0) && (n <= `SARCC_STEP_W'(`SARCC_NBITS)))
        begin
            m[`SARCC_NBITS - 32'(n)] = 1'b1;
        end
        return m;
    endfunction

    sarcc_sync u_req_sync
    (
        .clock    (clock),
        .srst     (srst),
        .async_in (convert_req),
        .sync_out (req_s)
    );

    sarcc_sync u_cmp_sync
    (
        .clock    (clock),
        .srst     (srst),
        .async_in (comp_keep),
        .sync_out (comp_s)
    );

    sarcc_clkgen u_clkgen
    (
        .clock (clock),
        .srst  (srst),
        .run   (!r_q.inhibit),
        .gclk  (g_lvl),
        .rise  (g_rise),
        .fall  (g_fall)
    );

    always_comb
    begin
        r_d          = r_q;
        r_d.req_prev = req_s;
        unique case (r_q.state)
            SARCC_IDLE:
            begin
                // Leading edge of the request raises status; the clock stays
                // inhibited until the trailing edge starts the conversion.
                if (req_s && !r_q.req_prev)
                begin
                    r_d.status = 1'b1;
                    r_d.state  = SARCC_ARMED;
                end
            end
            SARCC_ARMED:
            begin
                if (!req_s && r_q.req_prev)
                begin
                    r_d.trial   = `SARCC_ALL_ONES;
                    r_d.step    = '0;
                    r_d.falls   = '0;
                    r_d.inhibit = 1'b0;
                    r_d.state   = SARCC_STEP;
                end
            end
            SARCC_STEP:
            begin
                // Requests seen here are ignored until status drops.
                if (g_fall)
                begin
                    r_d.falls = r_q.falls + `SARCC_STEP_W'(1);
                end
                if (g_rise)
                begin
                    if (r_q.step == '0)
                    begin
                        r_d.trial = `SARCC_MSB_TRIAL;
                    end
                    else
                    begin
                        // Keep or reject bit n, then trial bit n+1.
                        r_d.trial = comp_s ? r_q.trial
                                           : (r_q.trial | bit_mask(r_q.step));
                        r_d.trial = r_d.trial & ~bit_mask(r_q.step + `SARCC_STEP_W'(1));
                    end
                    r_d.step = r_q.step + `SARCC_STEP_W'(1);
                    if (r_q.step == `SARCC_STEP_W'(`SARCC_NBITS))
                    begin
                        r_d.dly   = '0;
                        r_d.state = SARCC_HOLD;
                    end
                end
            end
            SARCC_HOLD:
            begin
                r_d.dly = r_q.dly + `SARCC_DLY_W'(1);
                // Stop the clock on its thirteenth fall. Otherwise the hold period
                // outlasts one clock period and lets a fourteenth rise out.
                if (g_fall)
                begin
                    r_d.falls   = r_q.falls + `SARCC_STEP_W'(1);
                    r_d.inhibit = 1'b1;
                end
                if (r_q.dly == `SARCC_DLY_W'(`SARCC_DONE_DELAY_CYC - 1))
                begin
                    r_d.status  = 1'b0;
                    r_d.inhibit = 1'b1;
                    r_d.state   = SARCC_IDLE;
                end
            end
        endcase
        if (srst)
        begin
            r_d          = '0;
            r_d.state    = SARCC_IDLE;
            r_d.inhibit  = 1'b1;
            r_d.trial    = `SARCC_ALL_ONES;
        end
    end

    always_ff @(posedge clock)
    begin
        r_q <= r_d;
    end

    // The trial register holds the complemented code: a kept bit is a 0 at
    // the pin, so the register drives the pins directly as negative-true.
    assign data_n    = r_q.trial;
    assign dac_code  = ~r_q.trial;
    assign msb_inv   = ~r_q.trial[`SARCC_NBITS-1];
    assign status    = r_q.status;
    assign gated_clk = g_lvl & ~r_q.inhibit;

    always_comb
    begin
        out_bundle         = '0;
        out_bundle.data_n  = data_n;
        out_bundle.msb_inv = msb_inv;
        out_bundle.status  = status;
        out_bundle.clk_out = gated_clk;
    end
endmodule

/* verif/sarcc_top_checker.sv */
// Purpose: Port-level checks of the conversion sequencer.
// Assumes: One clock domain; srst synchronous.
// Notes:   Helper counters track gated clock rises.
`timescale 1ns/1ps

module sarcc_top_checker
(
    input wire logic              clock,
    input wire logic              srst,
    input wire logic              convert_req,
    input sarcc_pkg::sarcc_word_t data_n,
    input wire logic              msb_inv,
    input wire logic              status,
    input wire logic              gated_clk,
    input sarcc_pkg::sarcc_word_t dac_code
);
    import sarcc_pkg::*;
    logic [3:0] rise_cnt_q;
    logic [7:0] since_q;

    // The since count reads one less than the cycles elapsed, as it restarts after the rise.
    always_ff @(posedge clock)
    begin
        if (srst || !status)
            rise_cnt_q <= 4'h0;
        else if ($rose(gated_clk))
            rise_cnt_q <= rise_cnt_q + 4'h1;
        if (srst || $rose(gated_clk))
            since_q <= 8'h00;
        else if (since_q != 8'hff)
            since_q <= since_q + 8'h01;
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    AST_MSB_INV: assert property (msb_inv == ~data_n[11])
        else $error("msb_inv wrong");
    AST_NEG_TRUE: assert property (dac_code == ~data_n)
        else $error("data_n not complement");
    AST_CLK_INHIBIT: assert property (!status |-> !gated_clk)
        else $error("gated_clk runs while idle");
    AST_STATUS_SET: assert property ($rose(convert_req) && !status |-> ##[1:4] status)
        else $error("status not set");
    AST_STATUS_HOLD: assert property (status && rise_cnt_q < 4'hd |=> status)
        else $error("status dropped early");
    AST_THIRTEEN: assert property ($fell(status) |-> rise_cnt_q == 4'hd)
        else $error("gated rise count wrong");
    AST_DONE_DELAY: assert property ($fell(status) |-> since_q == 8'h09)
        else $error("status fall delay wrong");
    AST_FIRST_TRIAL: assert property ($rose(gated_clk) && rise_cnt_q == 4'h0 |-> ##[0:2] data_n == 12'h7ff)
        else $error("first trial wrong");

    cover property ($fell(status));
    cover property (status && $rose(convert_req));
    cover property (rise_cnt_q == 4'hd);
endmodule

/* verif/sarcc_host.sv */
// Purpose: Host and comparator beside the conversion sequencer.
// Assumes: Requests issued on falling clock edges.
// Notes:   The comparator keeps a trial while the code is not above target.
`timescale 1ns/1ps

module sarcc_host
(
    input wire logic              clock,
    input wire logic [7:0]        start_seq,
    input wire logic              poke,
    input sarcc_pkg::sarcc_word_t target,
    input sarcc_pkg::sarcc_word_t dac_code,
    input sarcc_pkg::sarcc_word_t data_n,
    input wire logic              status,
    output logic                  convert_req,
    output logic                  comp_keep,
    output sarcc_pkg::sarcc_word_t captured,
    output logic [7:0]            done_seq
);
    import sarcc_pkg::*;
    logic req_q = 1'b0;
    assign convert_req = req_q | poke;
    assign comp_keep = (dac_code <= target);
    initial done_seq = 8'h00;
    always
    begin
        @(negedge clock iff (start_seq != done_seq));
        req_q = 1'b1;
        repeat (25) @(negedge clock);
        req_q = 1'b0;
        @(negedge status);
        captured = data_n;
        done_seq = start_seq;
    end
endmodule

/* verif/sarcc_top_tb.sv */
// Purpose: Self-checking bench of the conversion sequencer.
// Assumes: 250 MHz clock; the host model drives request and comparator.
// Notes:   Each scenario waits on the host's completion count.
`timescale 1ns/1ps

module sarcc_top_tb;
    import sarcc_pkg::*;
    logic        clock = 1'b0;
    logic        srst = 1'b1;
    logic        poke = 1'b0;
    logic [7:0]  start_seq = 8'h00;
    logic [7:0]  done_seq;
    sarcc_word_t target = 12'h000;
    sarcc_word_t data_n, dac_code, captured;
    sarcc_out_t  out_bundle;
    logic        convert_req, comp_keep, msb_inv, status, gated_clk;
    int          num_errors = 0;
    int          checks_done = 0;

    initial forever #2 clock = ~clock;

    sarcc_top uut (.clock(clock), .srst(srst), .convert_req(convert_req),
        .comp_keep(comp_keep), .data_n(data_n), .msb_inv(msb_inv), .status(status),
        .gated_clk(gated_clk), .dac_code(dac_code), .out_bundle(out_bundle));
    sarcc_host host (.clock(clock), .start_seq(start_seq), .poke(poke), .target(target),
        .dac_code(dac_code), .data_n(data_n), .status(status), .convert_req(convert_req),
        .comp_keep(comp_keep), .captured(captured), .done_seq(done_seq));

    task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic kick(input sarcc_word_t t);
        @(negedge clock);
        target = t;
        start_seq = start_seq + 8'h01;
    endtask

    task automatic wait_done();
        for (int i = 0; i < 400 && done_seq != start_seq; i++)
            @(negedge clock);
        check("done", {4'h0, done_seq}, {4'h0, start_seq});
    endtask

    task automatic test_codes();
        sarcc_word_t codes [6] = '{12'h000, 12'hfff, 12'h800, 12'h7ff, 12'h676, 12'h001};
        foreach (codes[i])
        begin
            kick(codes[i]);
            wait_done();
            check("data_n", captured, ~codes[i]);
            check("dac_code", dac_code, codes[i]);
            check("bundle", out_bundle.data_n, ~codes[i]);
            check("msb_inv", {11'h0, msb_inv}, {11'h0, codes[i][11]});
            check("idle", {10'h0, status, gated_clk}, 12'h000);
        end
    endtask

    // A second request in mid-conversion must leave the result untouched.
    task automatic test_refuse();
        kick(12'ha5a);
        repeat (60) @(negedge clock);
        poke = 1'b1;
        repeat (30) @(negedge clock);
        poke = 1'b0;
        wait_done();
        check("refused", captured, ~12'ha5a);
    endtask

    task automatic test_reset();
        kick(12'h3c3);
        repeat (70) @(negedge clock);
        srst = 1'b1;
        repeat (2) @(negedge clock);
        check("rst flags", {10'h0, status, gated_clk}, 12'h000);
        check("rst data_n", data_n, 12'hfff);
        check("rst dac", dac_code, 12'h000);
        srst = 1'b0;
        wait_done();
        kick(12'h3c3);
        wait_done();
        check("after rst", captured, ~12'h3c3);
    endtask

    initial
    begin
        repeat (8) @(negedge clock);
        srst = 1'b0;
        test_codes();
        test_refuse();
        test_reset();
        give_verdict();
    end

    initial
    begin
        #20000;
        num_errors++;
        give_verdict();
    end
endmodule

bind sarcc_top sarcc_top_checker u_chk (.clock(clock), .srst(srst),
    .convert_req(convert_req), .data_n(data_n), .msb_inv(msb_inv), .status(status),
    .gated_clk(gated_clk), .dac_code(dac_code));
